// File: src/adcp_consts.svh
// Purpose: Constants of the audio DAC control port (serial register map, fields, defaults)
// Assumes: 10 MHz system clock, serial link clocked by the controller
// Notes:   Bytes travel LSB first; register and data fields are bit-reversed in the byte
`ifndef ADCP_CONSTS_SVH
`define ADCP_CONSTS_SVH

// Device address field and transfer type codes (bit1,bit0)
`define ADCP_DEV_ADDR      6'h06
`define ADCP_TYPE_WRITE    2'h2
`define ADCP_TYPE_READ     2'h3

// Register addresses on the serial link
`define ADCP_REG_SYS       7'h00
`define ADCP_REG_SOUND     7'h10
`define ADCP_REG_VOLUME    7'h11
`define ADCP_REG_STATUS    7'h18
`define ADCP_REG_DEFAULTS  7'h7f

// Reset values of the writable registers
`define ADCP_SYS_DEFAULT   16'h2040
`define ADCP_SOUND_DEFAULT 16'h0001
`define ADCP_VOL_DEFAULT   16'h0000

// Field positions
`define ADCP_SYS_PON       13
`define ADCP_SYS_AUTOMUTE  6
`define ADCP_SND_MUTE      0
`define ADCP_SND_DE_LO     1
`define ADCP_SND_TR_LO     3
`define ADCP_SND_BB_LO     8
`define ADCP_SND_M_LO      12
`define ADCP_VOL_LO        0

// Bits per serial byte and bytes returned by a read
`define ADCP_BYTE_BITS     8
`define ADCP_READ_BYTES    3

`endif

// File: src/adcp_pkg.sv
// Purpose: Types of the audio DAC control port
// Assumes: Constants come from adcp_consts.svh
// Notes:   Types only
package adcp_pkg;

   // Transfer state after a device address byte
   typedef enum logic [2:0] {
      ST_IDLE,   // Not addressed, waiting for an address phase
      ST_WREG,   // Addressed for write, expecting register byte
      ST_WDATA,  // Taking two write data bytes
      ST_READ,   // Device drives the data line
      ST_SKIP    // Transfer over or not for this device
   } adcp_state_t;

endpackage : adcp_pkg

// File: src/adcp_pin_sync.sv
// Purpose: Two-flop synchronisers and edge finders for the serial pins
// Assumes: Pins are asynchronous to CLK_IN
// Notes:   First flop of each chain feeds only the second flop
`timescale 1ns/1ps
`default_nettype none

module adcp_pin_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Raw pins
   input  wire logic [WIDTH-1:0] pin_in,
   // Clean levels and edges
   output logic      [WIDTH-1:0] level_out,
   output logic      [WIDTH-1:0] rise_out,
   output logic      [WIDTH-1:0] fall_out
);

   logic [WIDTH-1:0] meta;   // First stage, read by second stage only
   logic [WIDTH-1:0] prev;   // Previous clean level for edges

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_sync
         // No reset on the chain, so a strap can be seen while reset is held
         always_ff @(posedge clk_in) begin
            meta[g]      <= pin_in[g];
            level_out[g] <= meta[g];
         end

         // Edge history follows the level in reset; an idle-high clock
         // line would otherwise show a false rise on release
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               prev[g] <= level_out[g];
            end else begin
               prev[g] <= level_out[g];
            end
         end

         assign rise_out[g] = ~rst_in & level_out[g] & ~prev[g];
         assign fall_out[g] = ~rst_in & ~level_out[g] & prev[g];
      end
   endgenerate

endmodule : adcp_pin_sync

`default_nettype wire

// File: src/adcp_top.sv
// Purpose: Control front-end of an audio DAC: pin control or three-wire serial control
// Assumes: Serial clock far slower than CLK_IN (800 ns vs 100 ns); strap static
// Notes:   Status inputs come from same-clock logic; serial pins are synchronised
`timescale 1ns/1ps
`default_nettype none
`include "adcp_consts.svh"

module adcp_top (
   // Clock and reset
   input  wire logic       CLK_IN,
   input  wire logic       RST_IN,
   // Strap and pin-mode mute
   input  wire logic       CONTROL_SCHEME_STRAP_IN,
   input  wire logic       MUTE_PIN_IN,
   // Serial link
   input  wire logic       SERIAL_CLOCK_LINE_IN,
   input  wire logic       SERIAL_MODE_LINE_IN,
   input  wire logic       SERIAL_DATA_LINE_IN,
   output logic            SERIAL_DATA_LINE_OUT,
   output logic            SERIAL_DATA_LINE_OE_OUT,
   // Status from decoder, clock regeneration and interpolator
   input  wire logic       PLL_LOCK_IN,
   input  wire logic       DECODER_LOCK_IN,
   input  wire logic       PCM_VALID_IN,
   input  wire logic [1:0] SAMPLE_RATE_STATUS_IN,
   input  wire logic       PREEMPHASIS_IN,
   input  wire logic [1:0] CLOCK_ACCURACY_STATUS_IN,
   input  wire logic       INTERP_MUTE_STATUS_IN,
   // Settings to the sound path
   output logic            SOFT_MUTE_OUT,
   output logic            AUTO_MUTE_ENABLE_OUT,
   output logic            POWER_ON_OUT,
   output logic [1:0]      DEEMPHASIS_OUT,
   output logic [1:0]      FILTER_MODE_OUT,
   output logic [3:0]      BASS_BOOST_OUT,
   output logic [1:0]      TREBLE_OUT,
   output logic [5:0]      VOLUME_OUT,
   // Status pins
   output logic            LOCK_OUT,
   output logic            STATIC_MODE_OUT
);

   // Reverse bit order of a byte; register and data fields sit reversed
   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7-i];
      end
      return rev8_ret(r);
   endfunction : rev8

   // Identity helper keeps the return path single
   function automatic logic [7:0] rev8_ret(input logic [7:0] b);
      return b;
   endfunction : rev8_ret

   // Default words as constants, so single fields can be picked out
   localparam logic [15:0] sys_def   = `ADCP_SYS_DEFAULT;
   localparam logic [15:0] sound_def = `ADCP_SOUND_DEFAULT;
   localparam logic [15:0] vol_def   = `ADCP_VOL_DEFAULT;

   // Synchronised pins: 0 clock, 1 mode, 2 data, 3 strap, 4 mute
   logic [4:0] pin_lvl;
   logic [4:0] pin_rise;
   logic [4:0] pin_fall;

   adcp_pin_sync #(.WIDTH(5)) u_sync (
      .clk_in    (CLK_IN),
      .rst_in    (RST_IN),
      .pin_in    ({MUTE_PIN_IN, CONTROL_SCHEME_STRAP_IN, SERIAL_DATA_LINE_IN,
                   SERIAL_MODE_LINE_IN, SERIAL_CLOCK_LINE_IN}),
      .level_out (pin_lvl),
      .rise_out  (pin_rise),
      .fall_out  (pin_fall)
   );

   logic        sclk_rise;              // Controller clock rising edge
   logic        mode_lvl;               // Mode line: low address, high data
   logic        mode_edge;              // Any change of the mode line
   logic        data_lvl;               // Data line sample
   assign sclk_rise = pin_rise[0];
   assign mode_lvl  = pin_lvl[1];
   assign mode_edge = pin_rise[1] | pin_fall[1];
   assign data_lvl  = pin_lvl[2];

   // Control scheme, caught while reset is held
   logic static_mode;                   // High: pin control
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         static_mode <= pin_lvl[3];
      end
   end

   // Serial shifter state
   logic                awake;          // Wake-up pulse seen
   logic [2:0]          bit_cnt;        // Bit within the byte
   logic [7:0]          shreg;          // Byte being received
   logic [1:0]          byte_idx;       // Byte within the data phase
   adcp_pkg::adcp_state_t state;
   logic [6:0]          reg_addr;       // Register selected for write or read
   logic [7:0]          data_hi;        // First write data byte
   logic [23:0]         tx_word;        // Address byte and two data bytes
   logic                wr_commit;      // One-cycle write strobe
   logic [15:0]         wr_data;        // Word being written

   logic       serial_on;               // Link is live only in serial mode
   logic       bit_take;                // Clock edge that carries a bit
   logic       byte_done;               // Eighth bit taken
   logic [7:0] byte_val;                // Completed byte, bit0 first in time
   assign serial_on = ~static_mode;
   assign bit_take  = serial_on & awake & sclk_rise;
   assign byte_done = bit_take & (bit_cnt == 3'h7);

   // Completed byte including the bit arriving now; LSB came first
   always_comb begin
      byte_val        = shreg;
      byte_val[7]     = data_lvl;
   end

   // Wake-up: first clock pulse after reset arms the link only
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         awake <= 1'b0;
      end else if (serial_on & sclk_rise) begin
         awake <= 1'b1;
      end
   end

   // Bit counter and shifter; a mode change restarts byte framing
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         bit_cnt <= 3'h0;
         shreg   <= 8'h00;
      end else if (mode_edge) begin
         bit_cnt <= 3'h0;
      end else if (bit_take) begin
         shreg[bit_cnt] <= data_lvl;
         bit_cnt        <= bit_cnt + 3'h1;
      end
   end

   // Address byte decode
   logic       dev_match;               // Address field is ours
   logic [1:0] xfer_type;               // Transfer type bits {bit1,bit0}
   assign dev_match = (byte_val[7:2] == `ADCP_DEV_ADDR);
   assign xfer_type = {byte_val[1], byte_val[0]};

   // Register number from a register byte: bit1 is A6, bit7 is A0
   logic [7:0] byte_rev;                // Register byte mirrored, A0 in bit0
   logic [6:0] byte_reg;
   assign byte_rev = rev8(byte_val);
   assign byte_reg = byte_rev[6:0];

   // Read word lookup for the selected register
   logic [15:0] rd_word;
   logic        rd_valid;
   logic [15:0] sys_reg;
   logic [15:0] sound_reg;
   logic [15:0] vol_reg;
   always_comb begin
      rd_word  = 16'h0000;
      rd_valid = 1'b1;
      case (reg_addr)
         `ADCP_REG_SYS:    rd_word = sys_reg;
         `ADCP_REG_SOUND:  rd_word = sound_reg;
         `ADCP_REG_VOLUME: rd_word = vol_reg;
         `ADCP_REG_STATUS: rd_word = {7'h00, CLOCK_ACCURACY_STATUS_IN, PREEMPHASIS_IN,
                                      PCM_VALID_IN, SAMPLE_RATE_STATUS_IN,
                                      DECODER_LOCK_IN, PLL_LOCK_IN,
                                      INTERP_MUTE_STATUS_IN};
         default:          rd_valid = 1'b0;
      endcase
   end

   // Transfer sequencer
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         state     <= adcp_pkg::ST_IDLE;
         byte_idx  <= 2'h0;
         reg_addr  <= 7'h00;
         data_hi   <= 8'h00;
         tx_word   <= 24'h000000;
         wr_commit <= 1'b0;
         wr_data   <= 16'h0000;
      end else begin
         wr_commit <= 1'b0;
         if (mode_edge) begin
            byte_idx <= 2'h0;
         end else if (byte_done & ~mode_lvl) begin
            // Address phase: select or deselect this device
            byte_idx <= 2'h0;
            if (!dev_match) begin
               state <= adcp_pkg::ST_SKIP;
            end else if (xfer_type == `ADCP_TYPE_WRITE) begin
               state <= adcp_pkg::ST_WREG;
            end else if (xfer_type == `ADCP_TYPE_READ) begin
               state   <= adcp_pkg::ST_READ;
               // Address byte: flag in bit0, A6..A0 in bits 1..7
               tx_word <= {rev8(rd_word[7:0]), rev8(rd_word[15:8]),
                           rev8({~rd_valid, reg_addr})};
            end else begin
               state <= adcp_pkg::ST_SKIP;
            end
         end else if (byte_done) begin
            byte_idx <= byte_idx + 2'h1;
            case (state)
               adcp_pkg::ST_WREG: begin
                  reg_addr <= byte_reg;
                  if (!byte_val[0]) begin
                     state <= adcp_pkg::ST_WDATA;
                  end else begin
                     state <= adcp_pkg::ST_SKIP;
                  end
               end
               adcp_pkg::ST_WDATA: begin
                  if (byte_idx == 2'h1) begin
                     data_hi <= rev8(byte_val);
                  end else begin
                     wr_data   <= {data_hi, rev8(byte_val)};
                     wr_commit <= 1'b1;
                     // New register needs a new device address
                     state     <= adcp_pkg::ST_SKIP;
                  end
               end
               adcp_pkg::ST_READ: begin
                  if (byte_idx == 2'(`ADCP_READ_BYTES - 1)) begin
                     state <= adcp_pkg::ST_SKIP;
                  end
               end
               default: begin
                  state <= state;                              // Bytes ignored
               end
            endcase
         end
      end
   end

   // Writable registers; restore-defaults reloads every one
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         sys_reg   <= `ADCP_SYS_DEFAULT;
         sound_reg <= `ADCP_SOUND_DEFAULT;
         vol_reg   <= `ADCP_VOL_DEFAULT;
      end else if (wr_commit) begin
         case (reg_addr)
            `ADCP_REG_SYS:    sys_reg   <= wr_data;
            `ADCP_REG_SOUND:  sound_reg <= wr_data;
            `ADCP_REG_VOLUME: vol_reg   <= wr_data;
            `ADCP_REG_DEFAULTS: begin
               sys_reg   <= `ADCP_SYS_DEFAULT;
               sound_reg <= `ADCP_SOUND_DEFAULT;
               vol_reg   <= `ADCP_VOL_DEFAULT;
            end
            default: begin
               sys_reg <= sys_reg;                             // Unknown target
            end
         endcase
      end
   end

   // Serial data out: bit of the current byte, driven only while reading
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         SERIAL_DATA_LINE_OUT    <= 1'b0;
         SERIAL_DATA_LINE_OE_OUT <= 1'b0;
      end else begin
         SERIAL_DATA_LINE_OE_OUT <= serial_on & mode_lvl &
                                    (state == adcp_pkg::ST_READ);
         SERIAL_DATA_LINE_OUT    <= tx_word[{byte_idx, bit_cnt}];
      end
   end

   // Settings: serial mode uses registers, pin mode uses defaults and the mute pin for soft mute
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         SOFT_MUTE_OUT        <= 1'b1;
         AUTO_MUTE_ENABLE_OUT <= 1'b1;
         POWER_ON_OUT         <= 1'b1;
         DEEMPHASIS_OUT       <= 2'h0;
         FILTER_MODE_OUT      <= 2'h0;
         BASS_BOOST_OUT       <= 4'h0;
         TREBLE_OUT           <= 2'h0;
         VOLUME_OUT           <= 6'h00;
      end else if (static_mode) begin
         SOFT_MUTE_OUT        <= pin_lvl[4];
         AUTO_MUTE_ENABLE_OUT <= sys_def[`ADCP_SYS_AUTOMUTE];
         POWER_ON_OUT         <= sys_def[`ADCP_SYS_PON];
         DEEMPHASIS_OUT       <= sound_def[`ADCP_SND_DE_LO +: 2];
         FILTER_MODE_OUT      <= sound_def[`ADCP_SND_M_LO +: 2];
         BASS_BOOST_OUT       <= sound_def[`ADCP_SND_BB_LO +: 4];
         TREBLE_OUT           <= sound_def[`ADCP_SND_TR_LO +: 2];
         VOLUME_OUT           <= vol_def[`ADCP_VOL_LO +: 6];
      end else begin
         SOFT_MUTE_OUT        <= sound_reg[`ADCP_SND_MUTE];
         AUTO_MUTE_ENABLE_OUT <= sys_reg[`ADCP_SYS_AUTOMUTE];
         POWER_ON_OUT         <= sys_reg[`ADCP_SYS_PON];
         DEEMPHASIS_OUT       <= sound_reg[`ADCP_SND_DE_LO +: 2];
         FILTER_MODE_OUT      <= sound_reg[`ADCP_SND_M_LO +: 2];
         BASS_BOOST_OUT       <= sound_reg[`ADCP_SND_BB_LO +: 4];
         TREBLE_OUT           <= sound_reg[`ADCP_SND_TR_LO +: 2];
         VOLUME_OUT           <= vol_reg[`ADCP_VOL_LO +: 6];
      end
   end

   // Lock pin and mode indication
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         LOCK_OUT        <= 1'b0;
         STATIC_MODE_OUT <= 1'b0;
      end else begin
         LOCK_OUT        <= PLL_LOCK_IN & DECODER_LOCK_IN & PCM_VALID_IN;
         STATIC_MODE_OUT <= static_mode;
      end
   end

   // Checks on the logic above
   a_lock_set: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (PLL_LOCK_IN && DECODER_LOCK_IN && PCM_VALID_IN) |=> LOCK_OUT)
      else $error("lock pin not raised");
   a_lock_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !(PLL_LOCK_IN && DECODER_LOCK_IN && PCM_VALID_IN) |=> !LOCK_OUT)
      else $error("lock pin high without full lock");
   a_mute_startup: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      $past(RST_IN) && !static_mode |-> ##1 SOFT_MUTE_OUT)
      else $error("serial mode not muted after reset");
   a_static_defaults: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      static_mode && $past(static_mode) |-> VOLUME_OUT == 6'h00
         && DEEMPHASIS_OUT == 2'h0 && POWER_ON_OUT)
      else $error("pin mode setting differs from default");
   a_static_mute: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      static_mode && pin_lvl[4] |=> SOFT_MUTE_OUT)
      else $error("mute pin ignored");
   a_no_drive_static: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      static_mode |=> !SERIAL_DATA_LINE_OE_OUT)
      else $error("data line driven in pin mode");
   a_byte_wrap: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      byte_done && !mode_edge |=> bit_cnt == 3'h0)
      else $error("byte framing not eight bits");
   a_read_select: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      byte_done && !mode_lvl && dev_match && xfer_type == 2'h3 && !mode_edge
      |=> state == adcp_pkg::ST_READ)
      else $error("read address did not start read");
   a_read_drive: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !static_mode && mode_lvl && state == adcp_pkg::ST_READ |=> SERIAL_DATA_LINE_OE_OUT)
      else $error("data line not driven during read");
   a_invalid_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      byte_done && !mode_lvl && dev_match && xfer_type == 2'h3 && !rd_valid && !mode_edge
      |=> tx_word[0])
      else $error("invalid register not flagged");
   a_write_apply: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      wr_commit && reg_addr == 7'h10 |=> sound_reg == $past(wr_data))
      else $error("write to sound register lost");

   c_write: cover property (@(posedge CLK_IN) disable iff (RST_IN) wr_commit);
   c_read: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      SERIAL_DATA_LINE_OE_OUT ##1 !SERIAL_DATA_LINE_OE_OUT);
   c_defaults: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      wr_commit && reg_addr == 7'h7f);

endmodule : adcp_top

`default_nettype wire

// File: verification/adcp_ctl_model.sv
// Purpose: Controller model that masters the three-wire serial control link
// Assumes: Link clock idles high between frames; bits move on its rising edge
// Notes:   Data line is released while the device answers; half period adjustable
`timescale 1ns/1ps
`default_nettype none

module adcp_ctl_model (
   // Link lines toward the device
   output var logic clk_out,
   output var logic mode_out,
   output var logic data_out,
   output var logic data_oe_out,
   // Resolved data line
   input  wire logic data_in
);
   int half = 400;   // Half of the 800 ns link period; raised for a slow controller

   // Idle link: clock high, address mode, data released
   initial begin
      clk_out = 1'b1;
      mode_out = 1'b0;
      data_out = 1'b0;
      data_oe_out = 1'b0;
   end

   // One clock pulse; the line is sampled just before the rising edge
   task automatic pulse(output logic b);
      clk_out = 1'b0;
      #half;
      b = data_in;
      clk_out = 1'b1;
      #half;
   endtask : pulse

   // Lone pulse after power-up, before any frame
   task automatic wake();
      logic b;
      pulse(b);
   endtask : wake

   // Byte to the device, first bit in time is bit 0
   task automatic send(input logic md, input logic [7:0] v);
      logic b;
      mode_out = md;
      data_oe_out = 1'b1;
      #half;
      for (int i = 0; i < 8; i++) begin
         data_out = v[i];
         pulse(b);
      end
   endtask : send

   // Byte from the device in data mode, gathered LSB first
   task automatic recv(output logic [7:0] v);
      data_oe_out = 1'b0;
      mode_out = 1'b1;
      #half;
      for (int i = 0; i < 8; i++) begin
         pulse(v[i]);
      end
   endtask : recv
endmodule : adcp_ctl_model
`default_nettype wire

// File: verification/testbench.sv
// Purpose: Self-checking bench of the audio DAC control port
// Assumes: 10 MHz clock, 800 ns link clock from the controller model
// Notes:   Random values from an xorshift seeded with 88
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic clk = 1'b0;   // System clock
   logic rst = 1'b1;   // Synchronous reset
   logic strap = 1'b0, mpin = 1'b0, pll = 1'b0, dec = 1'b0, pcm = 1'b0, pre = 1'b0, im = 1'b0;
   logic [1:0] rate = 2'h0, acc = 2'h0;   // Status fields
   logic [31:0] seed = 32'h58;            // Random state
   logic last = 1'b0, oe_seen = 1'b0;     // Stale line value, answer watch
   logic [7:0] a;                         // Returned address byte
   logic [15:0] v, d, st;                 // Data values
   wire sck, smd, cd, coe, dd, doe, mt, am, pon, lk, stm;
   wire [1:0] de, fm, tr;
   wire [3:0] bb;
   wire [5:0] vol;
   int fails = 0, compares = 0, cyc = 0;
   // Released line shows the inverse of its last level
   wire sdl = doe ? dd : (coe ? cd : ~last);

   always #50 clk = ~clk;

   adcp_ctl_model ctl (.clk_out(sck), .mode_out(smd), .data_out(cd), .data_oe_out(coe),
      .data_in(sdl));

   adcp_top dut (.CLK_IN(clk), .RST_IN(rst), .CONTROL_SCHEME_STRAP_IN(strap),
      .MUTE_PIN_IN(mpin), .SERIAL_CLOCK_LINE_IN(sck), .SERIAL_MODE_LINE_IN(smd),
      .SERIAL_DATA_LINE_IN(sdl), .SERIAL_DATA_LINE_OUT(dd), .SERIAL_DATA_LINE_OE_OUT(doe),
      .PLL_LOCK_IN(pll), .DECODER_LOCK_IN(dec), .PCM_VALID_IN(pcm),
      .SAMPLE_RATE_STATUS_IN(rate), .PREEMPHASIS_IN(pre), .CLOCK_ACCURACY_STATUS_IN(acc),
      .INTERP_MUTE_STATUS_IN(im), .SOFT_MUTE_OUT(mt), .AUTO_MUTE_ENABLE_OUT(am),
      .POWER_ON_OUT(pon), .DEEMPHASIS_OUT(de), .FILTER_MODE_OUT(fm), .BASS_BOOST_OUT(bb),
      .TREBLE_OUT(tr), .VOLUME_OUT(vol), .LOCK_OUT(lk), .STATIC_MODE_OUT(stm));

   // Cycle ceiling, stale line value and answer watch
   always @(posedge clk) begin
      last <= rst ? 1'b0 : sdl;
      oe_seen <= rst ? 1'b0 : (oe_seen | doe);
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction : xs

   // Bit order inside a byte is mirrored on the wire
   function automatic logic [7:0] rev8(input logic [7:0] x);
      for (int i = 0; i < 8; i++) rev8[i] = x[7-i];
   endfunction : rev8

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Four-byte write; address byte given whole so bad ones can be sent
   // Register byte given as {read flag, register} so prepare-reads can be sent
   task automatic wr(input logic [7:0] adr, input logic [7:0] r, input logic [15:0] x);
      ctl.send(1'b0, adr);
      ctl.send(1'b1, rev8(r));
      ctl.send(1'b1, rev8(x[15:8]));
      ctl.send(1'b1, rev8(x[7:0]));
      repeat (8) @(posedge clk);
      #1;
   endtask : wr

   // Prepare-read, read-type address, then three bytes back
   task automatic rd(input logic [6:0] r, output logic [7:0] ra, output logic [15:0] x);
      logic [7:0] b1, b2;
      ctl.send(1'b0, 8'h1a);
      ctl.send(1'b1, rev8({1'b1, r}));
      ctl.send(1'b0, 8'h1b);
      ctl.recv(ra);
      ctl.recv(b1);
      ctl.recv(b2);
      x = {rev8(b1), rev8(b2)};
      ctl.send(1'b0, 8'h00);
   endtask : rd

   task automatic end_of_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("dflt", 16'h0301, {6'h0, pon, am, stm, vol, mt});
      // Lock output follows the three conditions; mute pin has no say here
      repeat (24) begin
         seed = xs(seed);
         {pll, dec, pcm, mpin} = seed[3:0];
         @(posedge clk);
         #1;
         chk("lock", 16'(pll & dec & pcm), 16'(lk));
         chk("mute", 16'h1, 16'(mt));
      end
      ctl.wake();
      // Random settings through the write frame, one slow controller pass
      for (int i = 0; i < 5; i++) begin
         seed = xs(seed);
         v = seed[15:0];
         ctl.half = (i == 2) ? 700 : 400;
         wr(8'h1a, 8'h11, v);
         chk("vol", 16'(v[5:0]), 16'(vol));
         wr(8'h1a, 8'h10, v);
         chk("snd", 16'({v[0], v[2:1], v[4:3], v[11:8], v[13:12]}),
            16'({mt, de, tr, bb, fm}));
         wr(8'h1e, 8'h10, ~v);
         wr(8'h19, 8'h10, ~v);
         wr(8'h1a, 8'h90, ~v);
         chk("refuse", 16'({v[0], v[13:12]}), 16'({mt, fm}));
      end
      // Status read back with address echo, then an invalid register
      seed = xs(seed);
      {pll, dec, rate, pcm, pre, acc, im} = seed[9:0];
      st = {7'h0, acc, pre, pcm, rate, dec, pll, im};
      rd(7'h18, a, d);
      chk("raddr", 16'(rev8({1'b0, 7'h18})), 16'(a));
      chk("rdata", st, d);
      rd(7'h05, a, d);
      chk("bad", 16'(rev8({1'b1, 7'h05})), 16'(a));
      chk("bdat", 16'h0, d);
      wr(8'h1a, 8'h00, 16'h0);
      chk("sys", 16'h0, 16'({pon, am}));
      wr(8'h1a, 8'h7f, 16'h0);
      chk("rst", 16'h0301, {6'h0, pon, am, stm, vol, mt});
      // Pin control: link ignored, mute pin rules, defaults kept
      strap = 1'b1;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      for (int i = 0; i < 2; i++) begin
         mpin = i[0];
         repeat (6) @(posedge clk);
         #1;
         chk("pin", 16'({i[0], 1'b1, 2'h0}), 16'({mt, stm, de}));
      end
      rd(7'h18, a, d);
      chk("pinoe", 16'h0, 16'(oe_seen));
      chk("pinvol", 16'h0300, {6'h0, pon, am, 1'b0, vol, 1'b0});
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
